// ==== core/sac_dispatch_counter.sv ====
// How it works
// - A stage carries only if the lower stage carried and its bit is one.
// - Stage sum is bit xor carry; destination bit set only when sum is one.
// - Refresh and false-use cycles add one to the refresh address.
// - Instruction-fetch action cycles add one to the instruction address.
// - False-use action cycles load the order address into instruction register.
// - Sense clears common, up counter copies, dash clears, dash end loads sum.
// - Instruction increment uses the same four steps with its own gates.
// - Order load clears instruction register on up counter, gates on writing dash.
// - A checking flag records that the order address was really gated in.
// - With no enable, the instruction address goes into the common register.
// - Sense clears common; up counter loads refresh or instruction source.
// - Up counter loads only after a delay pulse with settled action state.
// - Ten stages whose half adder outputs equal common value plus one.
// - Lowest stage takes a constant one as its carry in.
// - The sum loads into refresh or instruction register by its gate.
`timescale 1ns/1ps
`default_nettype none

module sac_dispatch_counter import sac_pkg::*; #(
  parameter int W = SAC_W,
  parameter int CW = SAC_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [SAC_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [SAC_DW-1:0] avs_writedata,
  input wire logic [SAC_BEW-1:0] avs_byteenable,
  output logic [SAC_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Memory pulse train
  input wire logic action_sense_pulse,
  input wire logic delay_pulse,
  input wire logic up_counter_pulse,
  input wire logic writing_dash_pulse,
  input wire logic dash_end_pulse,
  // Memory control enables
  input wire logic action_refresh_state,
  input wire logic refresh_or_false_use_enable,
  input wire logic false_use_action_enable,
  input wire logic control_action_enable,
  // Order address source and check reset
  input wire logic [W-1:0] order_address,
  input wire logic check_reset,
  // Counter outputs
  output logic [W-1:0] dispatch_address,
  output logic [W-1:0] refresh_address,
  output logic [W-1:0] instr_address,
  output logic gated_to_counter_check
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Byte lane merge of a write into an old word
  function automatic logic [SAC_DW-1:0] be_merge(
    input logic [SAC_DW-1:0] old_val,
    input logic [SAC_DW-1:0] new_val,
    input logic [SAC_BEW-1:0] be
  );
    logic [SAC_DW-1:0] res;
    res = old_val;
    for (int b = 0; b < SAC_BEW; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // Zero extension of an address to a bus word
  function automatic logic [SAC_DW-1:0] widen(input logic [W-1:0] v);
    return {{(SAC_DW-W){1'b0}}, v};
  endfunction : widen

  // Event counter step with clear; the event wins
  function automatic logic [CW-1:0] cnt_step(
    input logic [CW-1:0] cur,
    input logic clr,
    input logic ev
  );
    logic [CW-1:0] res;
    res = cur;
    if (clr) begin
      res = ev ? {{(CW-1){1'b0}}, 1'b1} : SAC_CNT_RST;
    end else if (ev) begin
      res = cur + {{(CW-1){1'b0}}, 1'b1};
    end
    return res;
  endfunction : cnt_step

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [W-1:0] refresh_r;
  logic [W-1:0] instr_r;
  logic [W-1:0] dispatch_r;
  logic check_r, clash_r, spurious_r;
  logic [CW-1:0] refresh_cnt_r;
  logic [CW-1:0] instr_cnt_r;
  logic ack_r;
  logic [SAC_DW-1:0] rdata_r;

  // ----------------------------------------
  // Datapath helpers
  // ----------------------------------------
  logic [W-1:0] incremented;
  logic up_load, spurious, armed;
  logic enable_inverter;
  logic [W-1:0] dispatch_src;

  // Shared half adder chain on the common register
  sac_incr #(
    .W(W)
  ) u_incr (
    .dispatch(dispatch_r),
    .incremented(incremented),
    .carry_out()
  );

  // Up counter qualifier against glitches of the action state
  sac_pulse_qual u_qual (
    .clk(clk),
    .reset_n(reset_n),
    .action_sense_pulse(action_sense_pulse),
    .delay_pulse(delay_pulse),
    .up_counter_pulse(up_counter_pulse),
    .action_refresh_state(action_refresh_state),
    .up_load(up_load),
    .spurious(spurious),
    .armed(armed)
  );

  // ----------------------------------------
  // Gate decode
  // ----------------------------------------
  logic rf_clear, rf_gate, in_clear, in_gate, ord_clear, ord_gate;

  // Refresh clear and sum gate
  assign rf_clear = refresh_or_false_use_enable & writing_dash_pulse;
  assign rf_gate = refresh_or_false_use_enable & dash_end_pulse;
  // Instruction clear and sum gate
  assign in_clear = control_action_enable & writing_dash_pulse;
  assign in_gate = control_action_enable & dash_end_pulse;
  // Order address clear and gate
  assign ord_clear = false_use_action_enable & up_counter_pulse;
  assign ord_gate = false_use_action_enable & writing_dash_pulse;

  // Source for the common register
  assign enable_inverter = ~refresh_or_false_use_enable;
  assign dispatch_src = enable_inverter ? instr_r : refresh_r;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic req;
  logic wr_fire;
  logic [SAC_DW-1:0] rd_mux;
  logic [SAC_DW-1:0] status_word;
  logic [SAC_DW-1:0] ctrl_wdata;
  logic cnt_clr, chk_w1c, clash_w1c, spur_w1c;

  // One wait state, then the request completes
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_fire = avs_write & ack_r;
  assign avs_readdata = rdata_r;

  // Acknowledge one cycle after the request appears
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Status word layout
  always_comb begin
    status_word = SAC_DATA_RST;
    status_word[SAC_ST_CHECK] = check_r;
    status_word[SAC_ST_CLASH] = clash_r;
    status_word[SAC_ST_SPURIOUS] = spurious_r;
    status_word[SAC_ST_ARMED] = armed;
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_mux = SAC_DATA_RST;
    unique case (avs_address)
      SAC_OFS_REFRESH: rd_mux = widen(refresh_r);
      SAC_OFS_INSTR: rd_mux = widen(instr_r);
      SAC_OFS_DISPATCH: rd_mux = widen(dispatch_r);
      SAC_OFS_STATUS: rd_mux = status_word;
      SAC_OFS_COUNTS: rd_mux = {instr_cnt_r, refresh_cnt_r};
      default: rd_mux = SAC_DATA_RST;
    endcase
  end

  // Read data captured at the first edge of a read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r <= SAC_DATA_RST;
    end else if (avs_read && !ack_r) begin
      rdata_r <= rd_mux;
    end
  end

  // Write strobes for control and status
  assign ctrl_wdata = be_merge(SAC_DATA_RST, avs_writedata, avs_byteenable);
  assign cnt_clr = wr_fire & (avs_address == SAC_OFS_CTRL) & ctrl_wdata[SAC_CT_CNT_CLR];
  assign chk_w1c = wr_fire & (avs_address == SAC_OFS_STATUS) & ctrl_wdata[SAC_ST_CHECK];
  assign clash_w1c = wr_fire & (avs_address == SAC_OFS_STATUS) & ctrl_wdata[SAC_ST_CLASH];
  assign spur_w1c = wr_fire & (avs_address == SAC_OFS_STATUS) & ctrl_wdata[SAC_ST_SPURIOUS];

  // ----------------------------------------
  // Counter registers
  // ----------------------------------------
  logic sw_rf_wr;
  logic sw_in_wr;
  logic [SAC_DW-1:0] rf_merge;
  logic [SAC_DW-1:0] in_merge;

  // Software presets; pulse train gating takes priority
  assign sw_rf_wr = wr_fire & (avs_address == SAC_OFS_REFRESH);
  assign sw_in_wr = wr_fire & (avs_address == SAC_OFS_INSTR);
  assign rf_merge = be_merge(widen(refresh_r), avs_writedata, avs_byteenable);
  assign in_merge = be_merge(widen(instr_r), avs_writedata, avs_byteenable);

  // Refresh register: clear on writing dash, OR in sum on dash end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refresh_r <= SAC_ADDR_RST;
    end else if (rf_clear) begin
      refresh_r <= SAC_ADDR_RST;
    end else if (rf_gate) begin
      refresh_r <= refresh_r | incremented;
    end else if (sw_rf_wr) begin
      refresh_r <= rf_merge[W-1:0];
    end
  end

  // Instruction register: order load or its own increment
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      instr_r <= SAC_ADDR_RST;
    end else if (ord_clear) begin
      instr_r <= SAC_ADDR_RST;
    end else if (ord_gate) begin
      instr_r <= instr_r | order_address;
    end else if (in_clear) begin
      instr_r <= SAC_ADDR_RST;
    end else if (in_gate) begin
      instr_r <= instr_r | incremented;
    end else if (sw_in_wr) begin
      instr_r <= in_merge[W-1:0];
    end
  end

  // Common register: cleared on sense, loaded on qualified up counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dispatch_r <= SAC_ADDR_RST;
    end else if (action_sense_pulse) begin
      dispatch_r <= SAC_ADDR_RST;
    end else if (up_load) begin
      dispatch_r <= dispatch_r | dispatch_src;
    end
  end

  // ----------------------------------------
  // Flags and event counts
  // ----------------------------------------

  // Gated-to-counter check; a new gating beats a clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      check_r <= 1'b0;
    end else if (ord_gate) begin
      check_r <= 1'b1;
    end else if (check_reset || chk_w1c) begin
      check_r <= 1'b0;
    end
  end

  // Sticky record of overlapping enables from memory control
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clash_r <= 1'b0;
    end else if (control_action_enable &&
                 (refresh_or_false_use_enable || false_use_action_enable)) begin
      clash_r <= 1'b1;
    end else if (clash_w1c) begin
      clash_r <= 1'b0;
    end
  end

  // Sticky record of a rejected up counter pulse
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spurious_r <= 1'b0;
    end else if (spurious) begin
      spurious_r <= 1'b1;
    end else if (spur_w1c) begin
      spurious_r <= 1'b0;
    end
  end

  // Completed increments of each counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refresh_cnt_r <= SAC_CNT_RST;
      instr_cnt_r <= SAC_CNT_RST;
    end else begin
      refresh_cnt_r <= cnt_step(refresh_cnt_r, cnt_clr, rf_gate);
      instr_cnt_r <= cnt_step(instr_cnt_r, cnt_clr, in_gate);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dispatch_address = dispatch_r;
  assign refresh_address = refresh_r;
  assign instr_address = instr_r;
  assign gated_to_counter_check = check_r;

endmodule : sac_dispatch_counter

`default_nettype wire

// ==== core/sac_pkg.sv ====
package sac_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SAC_W = 10;
  localparam int SAC_CNT_W = 16;
  localparam int SAC_AW = 5;
  localparam int SAC_DW = 32;
  localparam int SAC_BEW = 4;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [SAC_AW-1:0] SAC_OFS_REFRESH = 5'h00;
  localparam logic [SAC_AW-1:0] SAC_OFS_INSTR = 5'h04;
  localparam logic [SAC_AW-1:0] SAC_OFS_DISPATCH = 5'h08;
  localparam logic [SAC_AW-1:0] SAC_OFS_STATUS = 5'h0c;
  localparam logic [SAC_AW-1:0] SAC_OFS_COUNTS = 5'h10;
  localparam logic [SAC_AW-1:0] SAC_OFS_CTRL = 5'h14;

  // ----------------------------------------
  // Status and control bit positions
  // ----------------------------------------
  localparam int SAC_ST_CHECK = 0;
  localparam int SAC_ST_CLASH = 1;
  localparam int SAC_ST_SPURIOUS = 2;
  localparam int SAC_ST_ARMED = 3;
  localparam int SAC_CT_CNT_CLR = 0;
  localparam int SAC_CNT_INSTR_LSB = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [SAC_W-1:0] SAC_ADDR_RST = 10'h000;
  localparam logic [SAC_CNT_W-1:0] SAC_CNT_RST = 16'h0000;
  localparam logic [SAC_DW-1:0] SAC_DATA_RST = 32'h0000_0000;

  // ----------------------------------------
  // Pulse qualifier states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SAC_QS_IDLE = 2'b00,
    SAC_QS_SENSED = 2'b01,
    SAC_QS_DELAYED = 2'b10
  } sac_qual_e;

endpackage : sac_pkg

// ==== core/sac_incr.sv ====
`timescale 1ns/1ps
`default_nettype none

module sac_incr import sac_pkg::*; #(
  parameter int W = SAC_W
) (
  // Common register value
  input wire logic [W-1:0] dispatch,
  // Half adder outputs
  output logic [W-1:0] incremented,
  output logic carry_out
);

  // ----------------------------------------
  // Ripple half adder chain
  // ----------------------------------------
  logic [W:0] carry;

  // One half adder and one carry gate per stage
  always_comb begin
    carry = '0;
    incremented = '0;
    carry[0] = 1'b1;
    for (int i = 0; i < W; i++) begin
      carry[i+1] = carry[i] & dispatch[i];
      incremented[i] = dispatch[i] ^ carry[i];
    end
  end

  // Top carry leaves the block; nothing reads it for the value
  assign carry_out = carry[W];

endmodule : sac_incr

`default_nettype wire

// ==== core/sac_pulse_qual.sv ====
`timescale 1ns/1ps
`default_nettype none

module sac_pulse_qual import sac_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory pulse train
  input wire logic action_sense_pulse,
  input wire logic delay_pulse,
  input wire logic up_counter_pulse,
  input wire logic action_refresh_state,
  // Qualified load and diagnostics
  output logic up_load,
  output logic spurious,
  output logic armed
);

  // ----------------------------------------
  // Sequence state
  // ----------------------------------------
  sac_qual_e state_r;
  logic held_state_r;
  logic stable;

  // State must not move between delay and up counter
  assign stable = (action_refresh_state == held_state_r);
  assign up_load = (state_r == SAC_QS_DELAYED) & up_counter_pulse & stable;
  assign spurious = up_counter_pulse & ~up_load;
  assign armed = (state_r != SAC_QS_IDLE);

  // Sense, then delay, then up counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= SAC_QS_IDLE;
    end else if (action_sense_pulse) begin
      state_r <= SAC_QS_SENSED;
    end else begin
      unique case (state_r)
        SAC_QS_IDLE: begin
          state_r <= SAC_QS_IDLE;
        end
        SAC_QS_SENSED: begin
          if (delay_pulse) begin
            state_r <= SAC_QS_DELAYED;
          end
        end
        SAC_QS_DELAYED: begin
          if (up_counter_pulse || !stable) begin
            state_r <= SAC_QS_IDLE;
          end
        end
        default: begin
          state_r <= SAC_QS_IDLE;
        end
      endcase
    end
  end

  // Action state captured once it has settled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      held_state_r <= 1'b0;
    end else if (state_r == SAC_QS_SENSED && delay_pulse) begin
      held_state_r <= action_refresh_state;
    end
  end

endmodule : sac_pulse_qual

`default_nettype wire

// ==== tb/sac_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Counter gating checks
// ----------------------------------------
module sac_checker #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pulse train and enables
  input wire logic action_sense_pulse,
  input wire logic delay_pulse,
  input wire logic up_counter_pulse,
  input wire logic writing_dash_pulse,
  input wire logic dash_end_pulse,
  input wire logic action_refresh_state,
  input wire logic refresh_or_false_use_enable,
  input wire logic false_use_action_enable,
  input wire logic control_action_enable,
  input wire logic [W-1:0] order_address,
  // Counter outputs
  input wire logic [W-1:0] dispatch_address,
  input wire logic [W-1:0] refresh_address,
  input wire logic [W-1:0] instr_address,
  input wire logic gated_to_counter_check
);
  default clocking dflt @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_SENSE_CLR: assert property (action_sense_pulse |=> dispatch_address == 10'h000)
    else $error("common register not cleared by sense");
  AST_UP_LOAD: assert property (
    delay_pulse ##[1:8] (up_counter_pulse && $stable(action_refresh_state)
    && dispatch_address == 10'h000) |=> dispatch_address == ($past(refresh_or_false_use_enable)
    ? $past(refresh_address) : $past(instr_address)))
    else $error("common register loaded from wrong source");
  AST_GLITCH: assert property (
    delay_pulse ##1 (up_counter_pulse && $changed(action_refresh_state))
    |=> dispatch_address == 10'h000)
    else $error("up pulse loaded after state twitch");
  AST_REF_CLR: assert property (
    writing_dash_pulse && refresh_or_false_use_enable |=> refresh_address == 10'h000)
    else $error("refresh register not cleared by dash");
  AST_REF_INC: assert property (
    dash_end_pulse && refresh_or_false_use_enable && refresh_address == 10'h000
    |=> refresh_address == $past(dispatch_address) + 10'h001)
    else $error("refresh register not advanced by one");
  AST_INSTR_INC: assert property (
    dash_end_pulse && control_action_enable && instr_address == 10'h000
    |=> instr_address == $past(dispatch_address) + 10'h001)
    else $error("instruction register not advanced by one");
  AST_ORDER_CLR: assert property (
    up_counter_pulse && false_use_action_enable |=> instr_address == 10'h000)
    else $error("instruction register not cleared for order load");
  AST_ORDER_LOAD: assert property (
    writing_dash_pulse && false_use_action_enable && instr_address == 10'h000
    |=> instr_address == $past(order_address) && gated_to_counter_check)
    else $error("order address not gated or not flagged");

  // Main scenarios reached
  cover property (dash_end_pulse && control_action_enable);
  cover property (writing_dash_pulse && false_use_action_enable);
  cover property (delay_pulse ##1 $changed(action_refresh_state));
endmodule : sac_checker

bind sac_dispatch_counter sac_checker #(.W(W)) u_chk (
  .clk(clk), .reset_n(reset_n), .action_sense_pulse(action_sense_pulse),
  .delay_pulse(delay_pulse), .up_counter_pulse(up_counter_pulse),
  .writing_dash_pulse(writing_dash_pulse), .dash_end_pulse(dash_end_pulse),
  .action_refresh_state(action_refresh_state),
  .refresh_or_false_use_enable(refresh_or_false_use_enable),
  .false_use_action_enable(false_use_action_enable),
  .control_action_enable(control_action_enable), .order_address(order_address),
  .dispatch_address(dispatch_address), .refresh_address(refresh_address),
  .instr_address(instr_address), .gated_to_counter_check(gated_to_counter_check)
);

`default_nettype wire

// ==== tb/sac_mem_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Memory control pulse train
// ----------------------------------------
module sac_mem_ctrl_model (
  // Clock and frame request
  input wire logic clk,
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic [1:0] gap,
  input wire logic glitch,
  // Sense, delay, up, dash, dash end
  output logic [4:0] pulse,
  // State and enables
  output logic ars,
  output logic rof_en,
  output logic fua_en,
  output logic cae_en,
  output logic busy
);
  // One pulse, then an idle gap
  task automatic step(input int k);
    pulse <= 5'h01 << k;
    if (k == 2 && glitch) ars <= 1'b1; // Twitch under the up pulse
    @(posedge clk);
    if (gap != 2'h0) begin
      pulse <= 5'h00;
      repeat (gap) @(posedge clk);
    end
  endtask : step

  // Idle levels, then the frame sequencer with enables held for the frame
  initial begin
    pulse = 5'h00;
    ars = 1'b1;
    {rof_en, fua_en, cae_en, busy} = 4'h0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        ars <= 1'b0;
        rof_en <= mode[0];
        fua_en <= (mode == 2'h3);
        cae_en <= (mode == 2'h2);
        for (int k = 0; k < 5; k++) step(k);
        pulse <= 5'h00;
        {rof_en, fua_en, cae_en, busy} <= 4'h0;
        ars <= 1'b1;
      end
    end
  end
endmodule : sac_mem_ctrl_model

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench import sac_pkg::*; ;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [SAC_AW-1:0] avs_address = '0;
  logic [SAC_DW-1:0] avs_writedata = '0;
  logic [SAC_DW-1:0] avs_readdata;
  logic avs_waitrequest;
  logic start = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] gap = 2'h0;
  logic glitch = 1'b0;
  logic check_reset = 1'b0;
  logic [SAC_W-1:0] order_address = '0;
  logic [4:0] pulse;
  logic ars, rof_en, fua_en, cae_en, busy, gated_to_counter_check;
  logic [SAC_W-1:0] dispatch_address, refresh_address, instr_address;
  int n_mismatch = 0;
  int comparisons = 0;

  sac_dispatch_counter uut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .action_sense_pulse(pulse[0]), .delay_pulse(pulse[1]), .up_counter_pulse(pulse[2]),
    .writing_dash_pulse(pulse[3]), .dash_end_pulse(pulse[4]),
    .action_refresh_state(ars), .refresh_or_false_use_enable(rof_en),
    .false_use_action_enable(fua_en), .control_action_enable(cae_en),
    .order_address(order_address), .check_reset(check_reset),
    .dispatch_address(dispatch_address), .refresh_address(refresh_address),
    .instr_address(instr_address), .gated_to_counter_check(gated_to_counter_check)
  );

  sac_mem_ctrl_model u_mc (
    .clk(clk), .start(start), .mode(mode), .gap(gap), .glitch(glitch), .pulse(pulse),
    .ars(ars), .rof_en(rof_en), .fua_en(fua_en), .cae_en(cae_en), .busy(busy)
  );

  // Clock
  always #25 clk = ~clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_mismatch++;
    $display("ERROR t=%0t wait ran out", $time);
    complete_run();
  endtask : hang

  // Next address, top carry dropped
  function automatic logic [9:0] nxt(input logic [9:0] a);
    logic [10:0] s;
    s = {1'b0, a} + 11'h001;
    return s[9:0];
  endfunction : nxt

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) hang();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  // One memory cycle through the partner
  task automatic frame(input logic [1:0] m, input logic [1:0] g, input logic gl);
    int n;
    mode <= m;
    gap <= g;
    glitch <= gl;
    start <= 1'b1;
    order_address <= 10'($urandom);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b1 && n < 10);
    if (busy !== 1'b1) hang();
    start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 60);
    if (busy !== 1'b0) hang();
    @(posedge clk);
  endtask : frame

  // Main sequence
  initial begin
    logic [31:0] q;
    logic [SAC_W-1:0] v;
    logic [SAC_AW-1:0] ofs;
    void'($urandom(32'h02aa));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, 5'h18, 32'hffff_ffff, q);
    bus(1'b1, SAC_OFS_DISPATCH, 32'hffff_ffff, q);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0, q);
      chk(q, 32'h0);
    end
    $display("test 1 done");
    for (int m = 1; m < 3; m++) begin
      ofs = (m == 1) ? SAC_OFS_REFRESH : SAC_OFS_INSTR;
      for (int i = 0; i < 8; i++) begin
        v = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($urandom);
        bus(1'b1, ofs, {22'h0, v}, q);
        frame(2'(m), 2'($urandom), 1'b0);
        chk({22'h0, dispatch_address}, {22'h0, v});
        bus(1'b0, ofs, 32'h0, q);
        chk(q, {22'h0, nxt(v)});
      end
    end
    bus(1'b0, SAC_OFS_COUNTS, 32'h0, q);
    chk(q, 32'h0008_0008);
    $display("test 2 done");
    v = 10'($urandom);
    bus(1'b1, SAC_OFS_REFRESH, {22'h0, v}, q);
    bus(1'b1, SAC_OFS_INSTR, 32'h0000_03ff, q);
    frame(2'h3, 2'h1, 1'b0);
    chk({22'h0, instr_address}, {22'h0, order_address});
    chk({22'h0, refresh_address}, {22'h0, nxt(v)});
    chk({31'h0, gated_to_counter_check}, 32'h1);
    check_reset <= 1'b1;
    @(posedge clk);
    check_reset <= 1'b0;
    @(posedge clk);
    chk({31'h0, gated_to_counter_check}, 32'h0);
    $display("test 3 done");
    bus(1'b1, SAC_OFS_INSTR, {22'h0, ~v}, q);
    frame(2'h0, 2'h2, 1'b0);
    chk({22'h0, dispatch_address}, {22'h0, ~v});
    chk({12'h0, refresh_address, instr_address}, {12'h0, nxt(v), ~v});
    $display("test 4 done");
    frame(2'h2, 2'h0, 1'b1);
    chk({22'h0, dispatch_address}, 32'h0);
    bus(1'b0, SAC_OFS_STATUS, 32'h0, q);
    chk(q, 32'h0000_0004);
    $display("test 5 done");
    bus(1'b1, SAC_OFS_STATUS, 32'h0000_0004, q);
    bus(1'b0, SAC_OFS_STATUS, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, SAC_OFS_COUNTS, 32'h0, q);
    chk(q, 32'h0009_0009);
    bus(1'b1, SAC_OFS_CTRL, 32'h0000_0001, q);
    bus(1'b0, SAC_OFS_COUNTS, 32'h0, q);
    chk(q, 32'h0);
    $display("test 6 done");
    complete_run();
  end
endmodule : testbench

`default_nettype wire
